// File: design/asb_pkg.sv
// Package of constants and types for the sample buffer
package asb_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_STATUS = 8'h11;
    localparam logic [7:0] ADDR_DATA   = 8'h1D;
    localparam logic [7:0] ADDR_MAP_A0 = 8'h2B;
    localparam logic [7:0] ADDR_MAP_B1 = 8'h2E;
    localparam logic [7:0] ADDR_CFG    = 8'h30;
    localparam logic [7:0] ADDR_THR    = 8'h31;
    localparam logic [7:0] ADDR_STEP   = 8'h01;

    // Field positions
    localparam int CFG_TAG_BIT  = 6;
    localparam int CFG_MODE_LSB = 4;
    localparam int CFG_EXT_BIT  = 3;
    localparam int CFG_THR_BIT  = 0;
    localparam int ST_READY_BIT = 4;
    localparam int ST_WM_BIT    = 3;
    localparam int ST_OVR_BIT   = 2;
    localparam int ST_FULL_BIT  = 1;
    localparam int MAP_A_IDX    = 0;
    localparam int MAP_B_IDX    = 2;

    // Depths and counts
    localparam logic [8:0] DEPTH_ALL   = 9'h140;
    localparam logic [8:0] DEPTH_THREE = 9'h13E;
    localparam logic [8:0] ONE9        = 9'h001;
    localparam logic [8:0] ZERO9       = 9'h000;
    localparam logic [1:0] SKID_DEPTH  = 2'h2;

    // Channel identifiers
    localparam logic [1:0] CH_X = 2'h0;
    localparam logic [1:0] CH_Y = 2'h1;
    localparam logic [1:0] CH_Z = 2'h2;
    localparam logic [1:0] CH_T = 2'h3;

    // Byte phases of the data port
    localparam logic [1:0] PH_TAG = 2'h0;
    localparam logic [1:0] PH_HI  = 2'h1;
    localparam logic [1:0] PH_LO  = 2'h2;

    typedef enum logic [1:0] {MODE_OFF, MODE_FIRST, MODE_LAST, MODE_TRIG} asb_mode_type;
    typedef enum logic [1:0] {TRIG_ARMED, TRIG_POST, TRIG_FROZEN} asb_trig_type;

    typedef struct packed {
        logic [1:0]  chan;
        logic [15:0] data;
    } asb_sample_type;

    typedef struct packed {
        logic       start;
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } asb_req_type;

    typedef struct packed {
        logic [7:0]                cfg;
        logic [7:0]                thr_low;
        logic [3:0][7:0]           map;
        logic [7:0]                ptr;
        logic [8:0]                rd_ptr;
        logic [8:0]                wr_ptr;
        logic [8:0]                count;
        logic [8:0]                post;
        asb_trig_type              trig;
        logic                      sync_d;
        logic                      ovr;
        logic [1:0]                phase;
        logic [7:0]                rdata;
        logic                      rvalid;
        logic                      irq_a;
        logic                      irq_b;
        logic [1:0]                skid_cnt;
        asb_sample_type [1:0]      skid;
    } asb_state_type;

    localparam asb_state_type ST_RESET = '0;

endpackage : asb_pkg

// File: design/asb_buffer.sv
// Sample buffer with register port, modes, flags and interrupt routing
// Operation
// - Tag enable puts channel id before samples
// - Ids: X 00, Y 01, Z 10, T 11
// - Id uses no location; burst gives id, sample
// - Sets stored interleaved; three channels leave 318-319
// - Mode 00 stores nothing, port reads zero
// - First-N stops when full, resumes on reads
// - Last-N drops oldest set when full
// - Trigger mode stores count more after trigger
// - Threshold is nine bits across two registers
// - Frame-sync pulse triggers when external enable set
// - Events route to two interrupt pins
// - Watermark set when count reaches threshold
// - Watermark interrupts only in first-N or last-N
// - Watermark clears when count drops below threshold
// - Ready flag high while samples wait
// - Overrun flag only in first-N and trigger
// - Overrun clears on data read or disable
// - Full at 320, or 318 with three channels
// - One unbounded burst drains whole buffer
// - Auto-increment stops at data port address
// - Pre-trigger samples frozen after capture
`timescale 1ns/1ps

module asb_buffer
    import asb_pkg::*;
(
    // Clock and reset
    input  wire logic           clock_i,
    input  wire logic           reset_i,
    // Register port
    input  wire asb_req_type    reg_req_i,
    output logic [7:0]          reg_rdata_o,
    output logic                reg_rvalid_o,
    // Sample stream from the datapath
    input  wire logic           smp_valid_i,
    input  wire asb_sample_type smp_i,
    output logic                smp_ready_o,
    // Sensor side controls
    input  wire logic [3:0]     chan_enable_i,
    input  wire logic           activity_i,
    input  wire logic           frame_sync_pin_i,
    // Interrupt pins
    output logic                irq_pin_a_o,
    output logic                irq_pin_b_o
);

    asb_state_type  st_reg;
    asb_state_type  st_next;
    asb_sample_type mem [0:DEPTH_ALL-1];
    asb_sample_type head;
    asb_mode_type   mode;
    logic [8:0]     thr;
    logic [8:0]     nch;
    logic [8:0]     cap;
    logic [7:0]     cur;
    logic [7:0]     stat;
    logic [7:0]     port_byte;
    logic [1:0]     ph;
    logic [1:0]     map_idx;
    logic [8:0]     cnt1;
    logic [8:0]     rp1;
    logic           tag;
    logic           acc;
    logic           port_rd;
    logic           pop;
    logic           have;
    logic           take;
    logic           write;
    logic           drop;
    logic           trig_ev;
    logic           wm_gate;

    // Pointer advance modulo the active depth
    function automatic logic [8:0] adv(input logic [8:0] p,
                                       input logic [8:0] k,
                                       input logic [8:0] c);
        logic [9:0] s;
        s = {1'b0, p} + {1'b0, k};
        if (s >= {1'b0, c}) begin
            s = s - {1'b0, c};
        end
        return s[8:0];
    endfunction : adv

    assign head        = mem[st_reg.rd_ptr];
    assign smp_ready_o = st_reg.skid_cnt != SKID_DEPTH;
    assign reg_rdata_o = st_reg.rdata;
    assign reg_rvalid_o = st_reg.rvalid;
    assign irq_pin_a_o = st_reg.irq_a;
    assign irq_pin_b_o = st_reg.irq_b;

    always_comb begin
        st_next = st_reg;
        mode    = asb_mode_type'(st_reg.cfg[CFG_MODE_LSB +: 2]);
        tag     = st_reg.cfg[CFG_TAG_BIT];
        thr     = {st_reg.cfg[CFG_THR_BIT], st_reg.thr_low};
        nch     = {7'h00, 2'(chan_enable_i[0] + chan_enable_i[1])}
                + {7'h00, 2'(chan_enable_i[2] + chan_enable_i[3])};
        cap     = (nch == 9'h003) ? DEPTH_THREE : DEPTH_ALL;
        have    = st_reg.skid_cnt != 2'h0;

        // Status byte
        stat = 8'h00;
        stat[ST_READY_BIT] = st_reg.count != ZERO9;
        stat[ST_WM_BIT]    = st_reg.count >= thr;
        stat[ST_OVR_BIT]   = st_reg.ovr;
        stat[ST_FULL_BIT]  = st_reg.count >= cap;

        // Address with auto-increment stopping at the data port
        cur     = reg_req_i.start ? reg_req_i.addr : st_reg.ptr;
        acc     = reg_req_i.rd | reg_req_i.wr;
        map_idx = 2'(cur - ADDR_MAP_A0);
        if (acc) begin
            st_next.ptr = (cur == ADDR_DATA) ? ADDR_DATA : cur + ADDR_STEP;
        end

        // Data port byte sequence
        port_rd   = reg_req_i.rd && (cur == ADDR_DATA);
        pop       = 1'b0;
        port_byte = 8'h00;
        ph        = (st_reg.phase == PH_TAG && !tag) ? PH_HI : st_reg.phase;
        if (mode != MODE_OFF && st_reg.count != ZERO9) begin
            case (ph)
                PH_TAG: begin
                    port_byte = {6'h00, head.chan};
                end
                PH_HI: begin
                    port_byte = head.data[15:8];
                end
                default: begin
                    port_byte = head.data[7:0];
                    pop       = port_rd;
                end
            endcase
            if (port_rd) begin
                st_next.phase = (ph == PH_LO) ? PH_TAG : ph + 2'h1;
            end
        end
        if (port_rd) begin
            st_next.ovr = 1'b0;
        end

        // Register writes
        if (reg_req_i.wr) begin
            if (cur == ADDR_CFG) begin
                st_next.cfg = reg_req_i.wdata;
            end else if (cur == ADDR_THR) begin
                st_next.thr_low = reg_req_i.wdata;
            end else if (cur >= ADDR_MAP_A0 && cur <= ADDR_MAP_B1) begin
                st_next.map[map_idx] = reg_req_i.wdata;
            end
        end

        // Register reads
        st_next.rvalid = reg_req_i.rd;
        if (reg_req_i.rd) begin
            if (cur == ADDR_STATUS) begin
                st_next.rdata = stat;
            end else if (cur == ADDR_DATA) begin
                st_next.rdata = port_byte;
            end else if (cur == ADDR_CFG) begin
                st_next.rdata = st_reg.cfg;
            end else if (cur == ADDR_THR) begin
                st_next.rdata = st_reg.thr_low;
            end else if (cur >= ADDR_MAP_A0 && cur <= ADDR_MAP_B1) begin
                st_next.rdata = st_reg.map[map_idx];
            end else begin
                st_next.rdata = 8'h00;
            end
        end

        cnt1 = st_reg.count - {8'h00, pop};
        rp1  = adv(st_reg.rd_ptr, {8'h00, pop}, cap);

        // Drain of the two-entry buffer into storage
        take  = have;
        write = 1'b0;
        case (mode)
            MODE_FIRST: begin
                take  = have && (cnt1 < cap);
                write = take;
            end
            MODE_LAST: begin
                write = have;
            end
            MODE_TRIG: begin
                write = have && (st_reg.trig != TRIG_FROZEN);
            end
            default: begin
                write = 1'b0;
            end
        endcase
        drop = write && (cnt1 >= cap) && (mode != MODE_FIRST);
        st_next.rd_ptr = drop ? adv(rp1, nch, cap) : rp1;
        st_next.count  = cnt1 - (drop ? nch : ZERO9) + {8'h00, write};
        st_next.wr_ptr = adv(st_reg.wr_ptr, {8'h00, write}, cap);

        // Overrun detection
        if ((mode == MODE_FIRST && smp_valid_i && !smp_ready_o)
            || (mode == MODE_TRIG && drop)) begin
            st_next.ovr = 1'b1;
        end

        // Skid buffer update
        if (take) begin
            st_next.skid[0]  = st_reg.skid[1];
            st_next.skid_cnt = st_reg.skid_cnt - 2'h1;
        end
        if (smp_valid_i && smp_ready_o) begin
            st_next.skid[st_next.skid_cnt[0]] = smp_i;
            st_next.skid_cnt = st_next.skid_cnt + 2'h1;
        end

        // Capture trigger
        st_next.sync_d = frame_sync_pin_i;
        trig_ev = activity_i
                || (st_reg.cfg[CFG_EXT_BIT] && frame_sync_pin_i && !st_reg.sync_d);
        case (st_reg.trig)
            TRIG_ARMED: begin
                if (mode == MODE_TRIG && trig_ev) begin
                    st_next.post = thr;
                    st_next.trig = (thr == ZERO9) ? TRIG_FROZEN : TRIG_POST;
                end
            end
            TRIG_POST: begin
                if (write) begin
                    st_next.post = st_reg.post - ONE9;
                    if (st_reg.post == ONE9) begin
                        st_next.trig = TRIG_FROZEN;
                    end
                end
            end
            default: begin
                st_next.trig = TRIG_FROZEN;
            end
        endcase
        if (mode != MODE_TRIG) begin
            st_next.trig = TRIG_ARMED;
        end

        // Disabled buffer holds nothing
        if (mode == MODE_OFF) begin
            st_next.count  = ZERO9;
            st_next.rd_ptr = ZERO9;
            st_next.wr_ptr = ZERO9;
            st_next.phase  = PH_TAG;
            st_next.ovr    = 1'b0;
        end

        // Interrupt routing
        wm_gate = mode == MODE_FIRST || mode == MODE_LAST;
        st_next.irq_a = |(stat & st_reg.map[MAP_A_IDX]
                          & ~((wm_gate ? 8'h00 : 8'h01) << ST_WM_BIT));
        st_next.irq_b = |(stat & st_reg.map[MAP_B_IDX]
                          & ~((wm_gate ? 8'h00 : 8'h01) << ST_WM_BIT));
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Sample storage
    always_ff @(posedge clock_i) begin
        if (write) begin
            mem[st_reg.wr_ptr] <= st_reg.skid[0];
        end
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);

    sequence s_port_rd;
        reg_req_i.rd && cur == ADDR_DATA;
    endsequence

    sequence s_stat_rd;
        reg_req_i.rd && cur == ADDR_STATUS;
    endsequence

    sequence s_freeze_quiet;
        st_reg.trig == TRIG_FROZEN ##1 !write;
    endsequence

    AST_OFF_ZERO: assert property (
        (s_port_rd ##0 mode == MODE_OFF) |=> reg_rdata_o == 8'h00)
        else $error("disabled buffer read not zero");

    AST_TAG_BYTE: assert property (
        (s_port_rd ##0 (mode != MODE_OFF && ph == PH_TAG && st_reg.count != ZERO9 && !write))
        |=> reg_rdata_o == {6'h00, $past(head.chan)} && st_reg.count == $past(st_reg.count))
        else $error("channel tag byte wrong");

    AST_READY_BIT: assert property (
        s_stat_rd |=> reg_rdata_o[ST_READY_BIT] == ($past(st_reg.count) != ZERO9))
        else $error("ready flag wrong");

    AST_WM_BIT: assert property (
        s_stat_rd |=> reg_rdata_o[ST_WM_BIT] == ($past(st_reg.count) >= $past(thr)))
        else $error("watermark flag wrong");

    AST_FULL_BIT: assert property (
        s_stat_rd |=> reg_rdata_o[ST_FULL_BIT] == ($past(st_reg.count) >= $past(cap)))
        else $error("full flag wrong");

    AST_FIRST_HOLD: assert property (
        mode == MODE_FIRST && st_reg.count == cap && !pop && !reg_req_i.wr
        |=> st_reg.count == $past(st_reg.count))
        else $error("first-N stored past full");

    AST_LAST_DROP: assert property (
        mode == MODE_LAST && st_reg.count == cap && write && !pop && !reg_req_i.wr
        |=> st_reg.count == $past(st_reg.count) - $past(nch) + ONE9)
        else $error("last-N did not drop one set");

    AST_OVR_OFF: assert property (
        mode == MODE_OFF |=> !st_reg.ovr)
        else $error("overrun kept while disabled");

    AST_OVR_SET: assert property (
        mode == MODE_FIRST && smp_valid_i && !smp_ready_o |=> st_reg.ovr)
        else $error("overrun not set");

    AST_WM_IRQ: assert property (
        mode == MODE_TRIG && st_reg.map[MAP_B_IDX] == (8'h01 << ST_WM_BIT)
        |=> !irq_pin_b_o)
        else $error("watermark interrupt in trigger mode");

    AST_AUTOINC: assert property (
        acc && cur == ADDR_DATA |=> st_reg.ptr == ADDR_DATA)
        else $error("address moved past data port");

    AST_POST_END: assert property (
        st_reg.trig == TRIG_POST && write && st_reg.post == ONE9 && mode == MODE_TRIG
        && !reg_req_i.wr |=> s_freeze_quiet)
        else $error("capture did not freeze after count");

    AST_FROZEN_HOLD: assert property (
        mode == MODE_TRIG && st_reg.trig == TRIG_FROZEN |-> !write)
        else $error("frozen buffer still written");

    AST_EXT_TRIG: assert property (
        mode == MODE_TRIG && st_reg.trig == TRIG_ARMED && st_reg.cfg[CFG_EXT_BIT]
        && frame_sync_pin_i && !st_reg.sync_d && thr != ZERO9 |=> st_reg.trig == TRIG_POST)
        else $error("frame-sync edge did not start capture");

    AST_OFF_FLUSH: assert property (
        mode == MODE_OFF |=> st_reg.count == ZERO9)
        else $error("disabled buffer kept samples");

    AST_FULL_STALL: assert property (
        mode == MODE_FIRST && st_reg.count >= cap && !pop |-> !write)
        else $error("first-N wrote while full");

    AST_OVR_CLR: assert property (
        (s_port_rd ##0 (!(mode == MODE_FIRST && smp_valid_i && !smp_ready_o)
                        && !(mode == MODE_TRIG && drop))) |=> !st_reg.ovr)
        else $error("overrun kept after data read");

    AST_WM_CLEAR: assert property (
        mode == MODE_LAST && st_reg.map[MAP_B_IDX] == (8'h01 << ST_WM_BIT)
        && st_reg.count < thr |=> !irq_pin_b_o)
        else $error("watermark interrupt below threshold");

    AST_FULL_IRQ: assert property (
        mode == MODE_FIRST && st_reg.map[MAP_A_IDX] == (8'h01 << ST_FULL_BIT)
        |=> irq_pin_a_o == $past(st_reg.count >= cap))
        else $error("full flag not routed to pin");

    AST_PTR_STEP: assert property (
        acc && cur != ADDR_DATA |=> st_reg.ptr == 8'($past(cur) + ADDR_STEP))
        else $error("address did not advance");

    AST_RVALID_ONE: assert property (
        1'b1 |=> reg_rvalid_o == $past(reg_req_i.rd))
        else $error("read answer not one cycle after strobe");

endmodule : asb_buffer

// File: tb/asb_host.sv
// Host model issuing register reads and writes
`timescale 1ns/1ps
module asb_host
    import asb_pkg::*;
(
    // Clock
    input  wire logic  clock_i,
    // Register port
    output asb_req_type req_o
);
    initial req_o = '0;

    task automatic xfer(input logic s, input logic r, input logic w,
                        input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        #1;
        req_o = '{s, r, w, a, d};
    endtask : xfer

    // Released lines show the inverse of the last value
    task automatic idle();
        @(posedge clock_i);
        #1;
        req_o = '{1'b0, 1'b0, 1'b0, ~req_o.addr, ~req_o.wdata};
    endtask : idle

    // n reads in one burst, start address given once
    task automatic burst(input logic [7:0] a, input int n);
        for (int i = 0; i < n; i++) begin
            xfer(i == 0, 1'b1, 1'b0, a, 8'h00);
        end
        idle();
    endtask : burst

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, 1'b0, 1'b1, a, d);
        idle();
    endtask : wr_reg
endmodule : asb_host

// File: tb/test_accel_sample_buffer.sv
// Self-checking testbench of the sample buffer
`timescale 1ns/1ps
module test_accel_sample_buffer
    import asb_pkg::*;
;
    logic           clock_i;
    logic           reset_i;
    logic           smp_valid_i;
    logic           activity_i;
    logic           frame_sync_pin_i;
    logic [3:0]     chan_en;
    asb_req_type    req;
    asb_sample_type smp;
    logic [7:0]     rdata;
    logic           rvalid;
    logic           smp_ready;
    logic           irq_a;
    logic           irq_b;
    logic [7:0]     exp_q [$];
    logic [15:0]    mem [0:399];
    logic [8:0]     depth;
    int             nch;
    int             fails;
    int             n_checks;
    int             seed;

    asb_buffer dut (
        .clock_i(clock_i), .reset_i(reset_i), .reg_req_i(req), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .smp_valid_i(smp_valid_i), .smp_i(smp),
        .smp_ready_o(smp_ready), .chan_enable_i(chan_en), .activity_i(activity_i),
        .frame_sync_pin_i(frame_sync_pin_i), .irq_pin_a_o(irq_a), .irq_pin_b_o(irq_b)
    );
    asb_host host (.clock_i(clock_i), .req_o(req));

    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test

    // Read monitor takes the oldest note
    always @(negedge clock_i) begin
        if (rvalid === 1'b1) check(rdata, exp_q.pop_front());
    end

    task automatic rd(input logic [7:0] a, input logic [7:0] b);
        exp_q.push_back(b);
        host.burst(a, 1);
        repeat (3) @(posedge clock_i);
        #1;
    endtask : rd

    task automatic setup(input logic [7:0] c, input logic [7:0] t);
        host.wr_reg(ADDR_CFG, c);
        host.wr_reg(ADDR_THR, t);
    endtask : setup

    task automatic send(input logic [1:0] c, input logic [15:0] d);
        int t;
        t = 0;
        @(posedge clock_i);
        #1;
        smp = '{c, d};
        smp_valid_i = 1'b1;
        @(posedge clock_i);
        while (smp_ready !== 1'b1 && t < 1000) begin
            t++;
            @(posedge clock_i);
        end
        if (t == 1000) fails++;
        #1;
        smp_valid_i = 1'b0;
        smp = ~smp;
    endtask : send

    task automatic fill(input int base, input int n, input int nc);
        for (int i = base; i < base + n; i++) begin
            mem[i] = 16'($random(seed));
            send(2'(i % nc), mem[i]);
        end
        repeat (4) @(posedge clock_i);
    endtask : fill

    task automatic drain(input int base, input int k, input int nc, input logic tag);
        for (int i = base; i < base + k; i++) begin
            if (tag) exp_q.push_back({6'h00, 2'(i % nc)});
            exp_q.push_back(mem[i][15:8]);
            exp_q.push_back(mem[i][7:0]);
        end
        host.burst(ADDR_DATA, tag ? 3 * k : 2 * k);
        repeat (4) @(posedge clock_i);
    endtask : drain

    task automatic pulse(input logic act);
        @(posedge clock_i);
        #1;
        if (act) activity_i = 1'b1;
        else frame_sync_pin_i = 1'b1;
        @(posedge clock_i);
        #1;
        activity_i = 1'b0;
        frame_sync_pin_i = 1'b0;
    endtask : pulse

    initial begin
        #2000000;
        fails++;
        finish_test();
    end

    initial begin
        seed = 12031;
        fails = 0;
        n_checks = 0;
        reset_i = 1'b1;
        smp_valid_i = 1'b0;
        smp = '0;
        activity_i = 1'b0;
        frame_sync_pin_i = 1'b0;
        chan_en = 4'hF;
        repeat (2) @(posedge clock_i);
        #1;
        reset_i = 1'b0;
        // Reset values, unmapped reads, pointer stop
        for (int i = 0; i < 8; i++) exp_q.push_back(8'h00);
        host.burst(ADDR_MAP_A0, 4);
        host.burst(8'h1B, 4);
        host.wr_reg(ADDR_MAP_A0, 8'h02);
        host.wr_reg(8'h2C, 8'hA5);
        host.wr_reg(8'h2D, 8'h08);
        host.wr_reg(ADDR_MAP_B1, 8'h5A);
        exp_q = '{8'h02, 8'hA5, 8'h08, 8'h5A, 8'h11, 8'h3E};
        host.burst(ADDR_MAP_A0, 4);
        setup(8'h11, 8'h3E);
        host.burst(ADDR_CFG, 2);
        repeat (4) @(posedge clock_i);
        $display("done: registers");
        // Disabled mode stores nothing
        setup(8'h00, 8'h01);
        fill(0, 4, 4);
        rd(ADDR_STATUS, 8'h00);
        exp_q = '{8'h00, 8'h00};
        host.burst(ADDR_DATA, 2);
        $display("done: disabled");
        // Tagged set in last-N
        setup(8'h60, 8'h04);
        fill(0, 4, 4);
        rd(ADDR_STATUS, 8'h18);
        drain(0, 4, 4, 1'b1);
        rd(ADDR_STATUS, 8'h00);
        $display("done: tagged");
        // First-N full with four and three channels
        for (int p = 0; p < 2; p++) begin
            nch = 4 - p;
            depth = p ? DEPTH_THREE : DEPTH_ALL;
            host.wr_reg(ADDR_CFG, 8'h00);
            chan_en = p ? 4'h7 : 4'hF;
            setup(8'h11, depth[7:0]);
            fill(0, depth, nch);
            rd(ADDR_STATUS, 8'h1A);
            check({7'h00, irq_a}, 8'h01);
            check({7'h00, irq_b}, 8'h01);
            @(posedge clock_i);
            #1;
            smp = '{CH_X, 16'h1234};
            smp_valid_i = 1'b1;
            repeat (6) @(posedge clock_i);
            #1;
            smp_valid_i = 1'b0;
            rd(ADDR_STATUS, 8'h1E);
            drain(0, nch, nch, 1'b0);
            rd(ADDR_STATUS, 8'h10);
            check({7'h00, irq_a}, 8'h00);
        end
        $display("done: first-N");
        // Last-N drops the oldest set
        host.wr_reg(ADDR_CFG, 8'h00);
        chan_en = 4'hF;
        setup(8'h21, 8'h40);
        fill(0, 324, 4);
        rd(ADDR_STATUS, 8'h1A);
        check({7'h00, irq_b}, 8'h01);
        drain(4, 4, 4, 1'b0);
        $display("done: last-N");
        // Trigger by frame sync, then by activity
        for (int s = 0; s < 2; s++) begin
            host.wr_reg(ADDR_CFG, 8'h00);
            setup(s ? 8'h30 : 8'h38, 8'h04);
            fill(0, 8, 4);
            pulse(s[0]);
            fill(8, 8, 4);
            rd(ADDR_STATUS, 8'h18);
            check({7'h00, irq_b}, 8'h00);
            drain(0, 12, 4, 1'b0);
            rd(ADDR_STATUS, 8'h00);
        end
        $display("done: trigger");
        finish_test();
    end
endmodule : test_accel_sample_buffer
